/* pkg/bdio_pkg.sv */
// Purpose: Shared constants of the board digital I/O expander
// Assumes: Byte-wide I2C targets, one clock
// Notes: Bit positions refer to the eight-bit port bytes
package bdio_pkg;
	// Target address on both buses
	localparam logic [6:0] BDIO_I2C_ADDR = 7'h20;
	// Port byte layout
	localparam int BDIO_FIXED_LSB = 0;
	localparam int BDIO_CFG_LSB = 4;
	// Control byte layout
	localparam int BDIO_COMMIT_BIT = 1;
	localparam int BDIO_GRPA_OUT_BIT = 2;
	localparam int BDIO_GRPB_OUT_BIT = 3;
	// Values after reset
	localparam logic [7:0] BDIO_PORT_RST = 8'hF0;
	localparam logic [7:0] BDIO_CTRL_RST = 8'hF0;
	localparam logic [1:0] BDIO_DIR_RST = 2'h0;
	localparam logic [3:0] BDIO_FIXED_OUT_RST = 4'hF;
	// Bits in one I2C byte
	localparam logic [3:0] BDIO_BYTE_BITS = 4'h8;
	typedef enum logic [6:0] {
		BDIO_ST_IDLE = 7'h01,
		BDIO_ST_ADDR = 7'h02,
		BDIO_ST_ACKA = 7'h04,
		BDIO_ST_WR = 7'h08,
		BDIO_ST_ACKW = 7'h10,
		BDIO_ST_RD = 7'h20,
		BDIO_ST_ACKR = 7'h40
	} bdio_state_e;
endpackage

/* pkg/bdio_i2c_if.sv */
// Purpose: Byte carrier between an I2C target and the port logic
// Assumes: Strobes are one-cycle pulses on mclk
// Notes: rd_data is sampled in the cycle before rd_stb pulses
`timescale 1ns/100ps
interface bdio_i2c_if;
	logic wr_stb;
	logic [7:0] wr_data;
	logic rd_stb;
	logic [7:0] rd_data;
	modport target
	(
		output wr_stb,
		output wr_data,
		output rd_stb,
		input rd_data
	);
	modport port
	(
		input wr_stb,
		input wr_data,
		input rd_stb,
		output rd_data
	);
endinterface

/* hdl/bdio_i2c_target.sv */
// Purpose: Single-byte I2C target at a fixed address, no register index
// Assumes: scl and sda sampled on mclk, far slower than mclk
// Notes: sda is open drain; sda_oe_n low means pulling low
`timescale 1ns/100ps
module bdio_i2c_target
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// I2C pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe_n,
	// Byte side
	bdio_i2c_if.target bus
);
	bdio_pkg::bdio_state_e state_q;
	logic scl_q;
	logic sda_q;
	logic [7:0] sh_q;
	logic [3:0] cnt_q;
	logic rw_q;
	logic drv_q;
	logic wr_stb_q;
	logic rd_stb_q;
	logic [7:0] wr_data_q;

	// ********************************
	// Bus condition decode
	// ********************************
	wire start_w = scl_in & scl_q & sda_q & ~sda_in;
	wire stop_w = scl_in & scl_q & ~sda_q & sda_in;
	wire rise_w = scl_in & ~scl_q;
	wire fall_w = ~scl_in & scl_q;
	wire full_w = (cnt_q == bdio_pkg::BDIO_BYTE_BITS);
	wire match_w = (sh_q[7:1] == bdio_pkg::BDIO_I2C_ADDR);

	assign sda_oe_n = ~drv_q;
	assign bus.wr_stb = wr_stb_q;
	assign bus.wr_data = wr_data_q;
	assign bus.rd_stb = rd_stb_q;

	always_ff @(posedge mclk)
	begin
		scl_q <= scl_in;
		sda_q <= sda_in;
	end

	// ********************************
	// Transfer sequencer
	// ********************************
	always_ff @(posedge mclk)
	begin
		wr_stb_q <= 1'b0;
		rd_stb_q <= 1'b0;
		if (reset)
		begin
			state_q <= bdio_pkg::BDIO_ST_IDLE;
			sh_q <= 8'h00;
			cnt_q <= 4'h0;
			rw_q <= 1'b0;
			drv_q <= 1'b0;
			wr_data_q <= 8'h00;
		end
		else if (start_w)
		begin
			state_q <= bdio_pkg::BDIO_ST_ADDR;
			cnt_q <= 4'h0;
			drv_q <= 1'b0;
		end
		else if (stop_w)
		begin
			state_q <= bdio_pkg::BDIO_ST_IDLE;
			drv_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				bdio_pkg::BDIO_ST_IDLE:
				begin
					drv_q <= 1'b0;
				end
				bdio_pkg::BDIO_ST_ADDR:
				begin
					if (rise_w)
					begin
						sh_q <= {sh_q[6:0], sda_in};
						cnt_q <= cnt_q + 4'h1;
					end
					else if (fall_w && full_w)
					begin
						rw_q <= sh_q[0];
						// Only our own address is acknowledged see RULE_07
						drv_q <= match_w;
						state_q <= match_w ? bdio_pkg::BDIO_ST_ACKA
							: bdio_pkg::BDIO_ST_IDLE;
					end
				end
				bdio_pkg::BDIO_ST_ACKA:
				begin
					if (fall_w)
					begin
						cnt_q <= 4'h0;
						if (rw_q)
						begin
							// Current port state sent, no index see RULE_19
							sh_q <= bus.rd_data;
							drv_q <= ~bus.rd_data[7];
							rd_stb_q <= 1'b1;
							state_q <= bdio_pkg::BDIO_ST_RD;
						end
						else
						begin
							drv_q <= 1'b0;
							state_q <= bdio_pkg::BDIO_ST_WR;
						end
					end
				end
				bdio_pkg::BDIO_ST_WR:
				begin
					if (rise_w)
					begin
						sh_q <= {sh_q[6:0], sda_in};
						cnt_q <= cnt_q + 4'h1;
					end
					else if (fall_w && full_w)
					begin
						// Each data byte is the full new value see RULE_19
						wr_stb_q <= 1'b1;
						wr_data_q <= sh_q;
						drv_q <= 1'b1;
						state_q <= bdio_pkg::BDIO_ST_ACKW;
					end
				end
				bdio_pkg::BDIO_ST_ACKW:
				begin
					if (fall_w)
					begin
						drv_q <= 1'b0;
						cnt_q <= 4'h0;
						state_q <= bdio_pkg::BDIO_ST_WR;
					end
				end
				bdio_pkg::BDIO_ST_RD:
				begin
					if (fall_w)
					begin
						cnt_q <= cnt_q + 4'h1;
						sh_q <= {sh_q[6:0], 1'b1};
						if (cnt_q == (bdio_pkg::BDIO_BYTE_BITS - 4'h1))
						begin
							drv_q <= 1'b0;
							state_q <= bdio_pkg::BDIO_ST_ACKR;
						end
						else
						begin
							drv_q <= ~sh_q[6];
						end
					end
				end
				bdio_pkg::BDIO_ST_ACKR:
				begin
					if (rise_w)
					begin
						rw_q <= ~sda_in;
					end
					else if (fall_w)
					begin
						cnt_q <= 4'h0;
						if (rw_q)
						begin
							sh_q <= bus.rd_data;
							drv_q <= ~bus.rd_data[7];
							rd_stb_q <= 1'b1;
							state_q <= bdio_pkg::BDIO_ST_RD;
						end
						else
						begin
							state_q <= bdio_pkg::BDIO_ST_IDLE;
						end
					end
				end
				default:
				begin
					state_q <= bdio_pkg::BDIO_ST_IDLE;
					drv_q <= 1'b0;
				end
			endcase
		end
	end
endmodule

/* hdl/bdio_top.sv */
// Purpose: Board digital I/O expander behind two I2C targets
// Assumes: All pins synchronous to mclk; open-drain pins as in/out/oe_n
// Notes: Bus one carries the port byte, bus two the direction control
//
// Behaviour
// RULE_01 - Port byte read returns fixed inputs in bits 0 to 3.
// RULE_02 - An undriven fixed input reads as zero.
// RULE_03 - Fixed open-drain outputs one to four follow four host lines.
// RULE_04 - Host raises control commit bit after each fixed output change.
// RULE_05 - Pins one/two and three/four each share one direction.
// RULE_06 - Configurable pins are port bits 4 to 7; bus two controls direction.
// RULE_07 - Both targets answer at address 0x20 on their own bus.
// RULE_08 - All inputs: host writes 0xF0 to both targets.
// RULE_09 - Pins 1,2 in, 3,4 out: 0x30, then 0xF8 and 0xFA.
// RULE_10 - Pins 1,2 out, 3,4 in: 0xC0, then 0xF4 and 0xF6.
// RULE_11 - All outputs: 0x00, then 0xFC and 0xFE.
// RULE_12 - Direction changes only on a rising commit bit of control byte.
// RULE_13 - All inputs: pin levels read in bits 4 to 7.
// RULE_14 - Pins 1,2 read in bits 4,5; bits 6,7 drive pins 3,4.
// RULE_15 - Pins 3,4 read in bits 6,7; bits 4,5 drive pins 1,2.
// RULE_16 - All outputs: written bits 4 to 7 drive pins one to four.
// RULE_17 - Alert line goes low when new configurable input data appears.
// RULE_18 - Output pins are open drain: pull low for zero, release for one.
// RULE_19 - Single byte write sets whole port; single byte read returns state.
`timescale 1ns/100ps
module bdio_top
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// First I2C bus, port byte
	input wire logic port_scl,
	input wire logic port_sda_in,
	output logic port_sda_out,
	output logic port_sda_oe_n,
	// Second I2C bus, direction control
	input wire logic ctrl_scl,
	input wire logic ctrl_sda_in,
	output logic ctrl_sda_out,
	output logic ctrl_sda_oe_n,
	// Fixed inputs, level and driven flag per input
	input wire logic [3:0] fixed_input_level,
	input wire logic [3:0] fixed_input_driven,
	// Host lines for fixed outputs one to four
	input wire logic [3:0] host_out_line,
	// Fixed open-drain outputs
	output logic [3:0] fixed_output_out,
	output logic [3:0] fixed_output_oe_n,
	// Configurable pins one to four
	input wire logic [3:0] config_pin_in,
	output logic [3:0] config_pin_out,
	output logic [3:0] config_pin_oe_n,
	// New-data alert to host
	output logic new_data_alert_n
);
	logic [7:0] port_q;
	logic [7:0] ctrl_q;
	logic [1:0] dir_q;
	logic [3:0] fixed_out_q;
	logic [3:0] cfg_oe_n_q;
	logic [3:0] fixed_oe_n_q;
	logic [3:0] seen_q;
	logic alert_n_q;
	logic port_oe_n_w;
	logic ctrl_oe_n_w;
	logic port_sda_oe_n_q;
	logic ctrl_sda_oe_n_q;

	bdio_i2c_if port_bus ();
	bdio_i2c_if ctrl_bus ();

	// ********************************
	// I2C targets
	// ********************************
	bdio_i2c_target u_port_tgt
	(
		.mclk(mclk),
		.reset(reset),
		.scl_in(port_scl),
		.sda_in(port_sda_in),
		.sda_oe_n(port_oe_n_w),
		.bus(port_bus.target)
	);

	bdio_i2c_target u_ctrl_tgt
	(
		.mclk(mclk),
		.reset(reset),
		.scl_in(ctrl_scl),
		.sda_in(ctrl_sda_in),
		.sda_oe_n(ctrl_oe_n_w),
		.bus(ctrl_bus.target)
	);

	// ********************************
	// Direction and read decode
	// ********************************
	// One direction bit per pair of pins see RULE_05
	wire [3:0] out_mask_w = {dir_q[1], dir_q[1], dir_q[0], dir_q[0]};
	// Rising edge of the commit bit see RULE_12
	wire commit_w = ctrl_bus.wr_stb
		& ctrl_bus.wr_data[bdio_pkg::BDIO_COMMIT_BIT]
		& ~ctrl_q[bdio_pkg::BDIO_COMMIT_BIT];
	wire [1:0] dir_next_w = {ctrl_bus.wr_data[bdio_pkg::BDIO_GRPB_OUT_BIT],
		ctrl_bus.wr_data[bdio_pkg::BDIO_GRPA_OUT_BIT]};
	// Undriven fixed inputs read low see RULE_02
	wire [3:0] fixed_rd_w = fixed_input_level & fixed_input_driven;
	wire [3:0] port_cfg_w = port_q[bdio_pkg::BDIO_CFG_LSB +: 4];
	// Inputs report pin level, outputs report latched value see RULE_13
	wire [3:0] cfg_rd_w = (config_pin_in & ~out_mask_w)
		| (port_cfg_w & out_mask_w);
	// Inputs in low nibble, pins in high nibble see RULE_01
	assign port_bus.rd_data = {cfg_rd_w, fixed_rd_w};
	assign ctrl_bus.rd_data = ctrl_q;
	// Open drain: low for zero, released for one see RULE_18
	wire [3:0] cfg_oe_n_d = ~(out_mask_w & ~port_cfg_w);
	// Input-mode levels only, output bits masked off see RULE_17
	wire [3:0] in_lvl_w = config_pin_in & ~out_mask_w;
	wire change_w = (in_lvl_w != seen_q);
	wire clear_w = port_bus.rd_stb;

	assign port_sda_out = 1'b0;
	assign ctrl_sda_out = 1'b0;
	assign port_sda_oe_n = port_sda_oe_n_q;
	assign ctrl_sda_oe_n = ctrl_sda_oe_n_q;
	assign fixed_output_out = 4'h0;
	assign config_pin_out = 4'h0;
	assign fixed_output_oe_n = fixed_oe_n_q;
	assign config_pin_oe_n = cfg_oe_n_q;
	assign new_data_alert_n = alert_n_q;

	// ********************************
	// Port and control registers
	// ********************************
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			port_q <= bdio_pkg::BDIO_PORT_RST;
		end
		else if (port_bus.wr_stb)
		begin
			// Bits 4 to 7 steer the configurable pins see RULE_16
			port_q <= port_bus.wr_data;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			ctrl_q <= bdio_pkg::BDIO_CTRL_RST;
		end
		else if (ctrl_bus.wr_stb)
		begin
			// Bus two byte is the internal direction control see RULE_06
			ctrl_q <= ctrl_bus.wr_data;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			dir_q <= bdio_pkg::BDIO_DIR_RST;
			fixed_out_q <= bdio_pkg::BDIO_FIXED_OUT_RST;
		end
		else if (commit_w)
		begin
			// Pairs move together, writes between commits wait see RULE_14
			dir_q <= dir_next_w;
			// Host levels refreshed on commit see RULE_04
			fixed_out_q <= host_out_line;
		end
	end

	// ********************************
	// Pin drivers
	// ********************************
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			cfg_oe_n_q <= 4'hF;
			fixed_oe_n_q <= 4'hF;
			port_sda_oe_n_q <= 1'b1;
			ctrl_sda_oe_n_q <= 1'b1;
		end
		else
		begin
			// Output pairs follow their port bits see RULE_15
			cfg_oe_n_q <= cfg_oe_n_d;
			// Fixed output n pulls low while its host line level latched at the last commit is low see RULE_03
			fixed_oe_n_q <= fixed_out_q;
			port_sda_oe_n_q <= port_oe_n_w;
			ctrl_sda_oe_n_q <= ctrl_oe_n_w;
		end
	end

	// ********************************
	// New-data alert
	// ********************************
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			// Track idle pin levels so release raises no false alert
			seen_q <= in_lvl_w;
			alert_n_q <= 1'b1;
		end
		else
		begin
			seen_q <= in_lvl_w;
			// A fresh change beats a read in the same cycle see RULE_17
			if (change_w)
			begin
				alert_n_q <= 1'b0;
			end
			else if (clear_w)
			begin
				alert_n_q <= 1'b1;
			end
		end
	end
endmodule

/* verif/bdio_host_model.sv */
// Purpose: Host I2C controller model for one bus
// Assumes: Open-drain bus, wire level fed back on sda
// Notes: half sets the SCL phase length in mclk
`timescale 1ns/100ps
module bdio_host_model
(
	// Clock
	input wire logic mclk,
	// Bus
	input wire logic sda,
	output logic scl,
	output logic sda_drv
);
	int half = 6;
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic put(input logic b);
		tick(2);
		sda_drv = b;
		tick(half);
		scl = 1'b1;
		tick(half);
		scl = 1'b0;
	endtask
	task automatic get(output logic b);
		tick(2);
		sda_drv = 1'b1;
		tick(half);
		scl = 1'b1;
		tick(half);
		b = sda;
		scl = 1'b0;
	endtask
	// START, address, one whole byte, STOP
	task automatic xfer(input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ack);
		logic b;
		q = 8'h00;
		sda_drv = 1'b0;
		tick(half);
		scl = 1'b0;
		for (int i = 7; i >= 0; i--)
			put(a[i]);
		get(b);
		ack = !b;
		for (int i = 7; i >= 0 && ack; i--)
		begin
			if (a[0])
				get(q[i]);
			else
				put(d[i]);
		end
		if (ack && a[0])
			put(1'b1);
		else if (ack)
		begin
			get(b);
			ack = !b;
		end
		tick(2);
		sda_drv = 1'b0;
		tick(half);
		scl = 1'b1;
		tick(half);
		sda_drv = 1'b1;
		tick(half);
	endtask
endmodule

/* verif/bdio_top_sva.sv */
// Purpose: Port checks of the expander top
// Assumes: SCL phases last several mclk
// Notes: Bound at the foot of this file
`timescale 1ns/100ps
module bdio_top_sva
(
	// Clock, reset
	input wire logic mclk,
	input wire logic reset,
	// Buses
	input wire logic port_scl,
	input wire logic port_sda_oe_n,
	input wire logic port_sda_out,
	input wire logic ctrl_sda_out,
	input wire logic ctrl_scl,
	input wire logic ctrl_sda_oe_n,
	// Pins
	input wire logic [3:0] host_out_line,
	input wire logic [3:0] fixed_output_out,
	input wire logic [3:0] fixed_output_oe_n,
	input wire logic [3:0] config_pin_out,
	input wire logic [3:0] config_pin_oe_n,
	input wire logic new_data_alert_n
);
	logic [3:0] age_q;
	logic [3:0] age_d;
	// Cycles since the port target last pulled SDA
	assign age_d = !port_sda_oe_n ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
	always_ff @(posedge mclk)
		age_q <= reset ? 4'hF : age_d;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	chk_port_sda_edge:
	assert property ($changed(port_sda_oe_n) |-> !port_scl)
		else $error("port sda moved with scl high");
	chk_ctrl_sda_edge:
	assert property ($changed(ctrl_sda_oe_n) |-> !ctrl_scl)
		else $error("ctrl sda moved with scl high");
	chk_open_drain:
	assert property (config_pin_out == 4'h0 && fixed_output_out == 4'h0
		&& port_sda_out == 1'b0 && ctrl_sda_out == 1'b0)
		else $error("open drain value not zero");
	chk_fixed_hold:
	assert property ($stable(ctrl_scl) [*8] |-> $stable(fixed_output_oe_n))
		else $error("fixed output moved without commit");
	chk_fixed_value:
	assert property ($changed(fixed_output_oe_n) |->
		fixed_output_oe_n == $past(host_out_line, 2))
		else $error("fixed output not host line");
	chk_pin_timing:
	assert property ($changed(config_pin_oe_n) |->
		$past(!port_scl, 2) || $past(!ctrl_scl, 2))
		else $error("pin moved outside bus write");
	chk_alert_clear:
	assert property ($rose(new_data_alert_n) |-> age_q <= 4'h6)
		else $error("alert cleared without read");
	chk_alert_hold:
	assert property (!new_data_alert_n && age_q > 4'h8 |=> !new_data_alert_n)
		else $error("alert dropped early");
	cover property ($fell(new_data_alert_n));
	cover property ($changed(fixed_output_oe_n));
	cover property (config_pin_oe_n == 4'h0);
endmodule
bind bdio_top bdio_top_sva u_sva (.mclk, .reset, .port_scl, .port_sda_oe_n,
	.port_sda_out, .ctrl_sda_out,
	.ctrl_scl, .ctrl_sda_oe_n, .host_out_line, .fixed_output_out,
	.fixed_output_oe_n, .config_pin_out, .config_pin_oe_n, .new_data_alert_n);

/* verif/bdio_top_tb.sv */
// Purpose: Self-checking bench of the expander top
// Assumes: One host model on each I2C bus
// Notes: Bus and configurable pin wire levels are built here from their enables
`timescale 1ns/100ps
module bdio_top_tb;
	localparam logic [7:0] WA = {bdio_pkg::BDIO_I2C_ADDR, 1'b0};
	logic mclk;
	logic reset;
	logic p_scl, p_drv, p_oe_n, c_scl, c_drv, c_oe_n, alert_n, ack;
	logic [3:0] lvl, drv, hline, pin_ext, fo_oe_n, cp_oe_n, mask, fexp;
	logic [7:0] q, preg;
	wire p_sda = p_drv & p_oe_n;
	wire c_sda = c_drv & c_oe_n;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	bdio_top dut
	(
		.mclk(mclk), .reset(reset),
		.port_scl(p_scl), .port_sda_in(p_sda), .port_sda_out(),
		.port_sda_oe_n(p_oe_n),
		.ctrl_scl(c_scl), .ctrl_sda_in(c_sda), .ctrl_sda_out(),
		.ctrl_sda_oe_n(c_oe_n),
		.fixed_input_level(lvl), .fixed_input_driven(drv),
		.host_out_line(hline), .fixed_output_out(),
		.fixed_output_oe_n(fo_oe_n),
		.config_pin_in(pin_ext & cp_oe_n), .config_pin_out(),
		.config_pin_oe_n(cp_oe_n), .new_data_alert_n(alert_n)
	);
	bdio_host_model hp (.mclk(mclk), .sda(p_sda), .scl(p_scl), .sda_drv(p_drv));
	bdio_host_model hc (.mclk(mclk), .sda(c_sda), .scl(c_scl), .sda_drv(c_drv));
	initial
	begin
		mclk = 1'b0;
		forever
			#2 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			$display("mismatch t=%0t timeout", $time);
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [3:0] eoe();
		return ~(mask & ~preg[7:4]);
	endfunction
	function automatic logic [7:0] erd();
		return {(mask & preg[7:4]) | (~mask & pin_ext & eoe()), lvl & drv};
	endfunction
	task automatic acc(input logic ctl, input logic [7:0] a, d);
		if (ctl)
			hc.xfer(a, d, q, ack);
		else
			hp.xfer(a, d, q, ack);
		chk({7'h0, ack}, 8'h01);
		repeat (6) @(posedge mclk);
		#1;
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_init();
		chk({3'h0, alert_n, cp_oe_n}, 8'h1F);
		chk({4'h0, fo_oe_n}, {4'h0, fexp});
		acc(0, WA | 8'h01, 8'h00);
		chk(q, erd());
		acc(1, WA | 8'h01, 8'h00);
		chk(q, 8'hF0);
		hp.xfer(8'h42, 8'h00, q, ack);
		chk({7'h0, ack}, 8'h00);
	endtask
	task automatic t_alert();
		int n = 0;
		pin_ext = 4'h3;
		while (alert_n !== 1'b0 && n < 20)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk({7'h0, alert_n}, 8'h00);
		acc(0, WA | 8'h01, 8'h00);
		chk(q, erd());
		chk({7'h0, alert_n}, 8'h01);
	endtask
	task automatic t_cfg(input logic [7:0] pv, ca, cb, input logic [3:0] m);
		acc(0, WA, pv);
		preg = pv;
		chk({4'h0, cp_oe_n}, {4'h0, eoe()});
		acc(1, WA, ca);
		chk({4'h0, cp_oe_n}, {4'h0, eoe()});
		acc(1, WA, cb);
		mask = m;
		if (cb != ca)
			fexp = hline;
		chk({4'h0, cp_oe_n}, {4'h0, eoe()});
		acc(0, WA | 8'h01, 8'h00);
		chk(q, erd());
		chk({4'h0, fo_oe_n}, {4'h0, fexp});
	endtask
	task automatic t_fix();
		hline = 4'h6;
		acc(0, WA, 8'h50);
		preg = 8'h50;
		chk({4'h0, cp_oe_n}, {4'h0, eoe()});
		acc(0, WA | 8'h01, 8'h00);
		chk(q, erd());
		chk({4'h0, fo_oe_n}, {4'h0, fexp});
		hc.half = 12;
		acc(1, WA, 8'hFC);
		acc(1, WA, 8'hFE);
		fexp = hline;
		chk({4'h0, fo_oe_n}, {4'h0, fexp});
		hc.half = 6;
	endtask
	initial
	begin
		reset = 1'b1;
		lvl = 4'h5;
		drv = 4'h3;
		hline = 4'h9;
		pin_ext = 4'hA;
		preg = 8'hF0;
		mask = 4'h0;
		fexp = 4'hF;
		repeat (12) @(posedge mclk);
		#1;
		reset = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		t_init();
		t_alert();
		t_cfg(8'hF0, 8'hF0, 8'hF0, 4'h0);
		t_cfg(8'h30, 8'hF8, 8'hFA, 4'hC);
		t_cfg(8'hC0, 8'hF4, 8'hF6, 4'h3);
		t_cfg(8'h00, 8'hFC, 8'hFE, 4'hF);
		t_fix();
		end_of_test();
	end
endmodule
